//--- dv/dsac_bank_sva.sv
// Port-level concurrent checks for the active configuration bank
`timescale 1ns/100ps
`default_nettype none
module dsac_bank_sva (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // APB answer
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Address pre-decode
  input wire logic [43:0] SYS_ADDR,
  input wire logic [43:0] DEC_ADDR,
  // Low power
  input wire logic RANK_IDLE,
  input wire logic MEM_LOW_STATE,
  input wire logic SREF_REQ,
  input wire logic PDOWN_REQ,
  input wire logic MEM_CLK_STOP,
  // Row streaks
  input wire logic ROW_HIT,
  input wire logic ROW_MISS,
  input wire logic ROW_CAP_HIT
);
  // ----------------------------------------------------------------
  // Single domain: one clock and reset for every property
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("No answer in the cycle after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("Answer held longer than one cycle");
  a_idle_bus_quiet: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("Read data or error outside an answer");
  a_error_no_data: assert property (PSLVERR |-> PRDATA == 32'h0)
    else $error("Data returned with an error");
  // Past sample taken only once reset has been gone for a full cycle
  a_low_bits_pass: assert property ($past(RESET_N) |-> DEC_ADDR[27:0] == $past(SYS_ADDR[27:0]))
    else $error("Low address bits altered by decode");
  a_mask_only_clears: assert property ($past(RESET_N) |->
      (DEC_ADDR[43:28] & ~$past(SYS_ADDR[43:28])) == 16'h0000)
    else $error("Upper mask set a bit");
  a_sref_needs_idle: assert property (SREF_REQ |-> $past(RANK_IDLE))
    else $error("Self-refresh asked of a busy rank");
  a_pdown_needs_idle: assert property (PDOWN_REQ |-> $past(RANK_IDLE))
    else $error("Power-down asked while busy");
  a_clk_stop_low: assert property (MEM_CLK_STOP |-> $past(MEM_LOW_STATE))
    else $error("Clock stopped outside a low state");
  a_miss_clears_cap: assert property (ROW_MISS ##1 !ROW_HIT |=> !ROW_CAP_HIT)
    else $error("Row cap held after a miss");
endmodule // dsac_bank_sva

bind dsac_bank dsac_bank_sva dsac_bank_sva_inst (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SYS_ADDR(SYS_ADDR),
  .DEC_ADDR(DEC_ADDR), .RANK_IDLE(RANK_IDLE), .MEM_LOW_STATE(MEM_LOW_STATE),
  .SREF_REQ(SREF_REQ), .PDOWN_REQ(PDOWN_REQ), .MEM_CLK_STOP(MEM_CLK_STOP),
  .ROW_HIT(ROW_HIT), .ROW_MISS(ROW_MISS), .ROW_CAP_HIT(ROW_CAP_HIT)
);
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the active configuration bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dsac_pkg::*;
  // ----------------------------------------------------------------
  // Signals, bank inputs given a value at time zero
  // ----------------------------------------------------------------
  typedef struct {logic [3:0] st; logic [15:0] a; logic [31:0] d; logic e;} dsac_row_t;
  logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, sref_req, pdown_req, clk_stop, turn_allowed;
  logic row_cap_hit, row_precedence, rd_suppress, esc_pulse;
  logic [31:0] prog [9] = '{default: 32'hFFFFFFFF}; // Programmed copies, all bits set
  logic [3:0] ctrl = 4'h8, req_qos = 4'h0, req_priority;
  logic [43:0] sys_addr = 44'hABC_DEF0_2D5B, dec_addr;
  logic [1:0] dec_page_lsb, dec_pattern, req_class, wait_class = 2'h0;
  logic [2:0] dec_mode;
  logic rank_idle = 1'b0, mem_low = 1'b0;
  logic [3:0] stb = 4'h0; // Strobes: refresh tick, row hit, row miss, turn done
  logic [7:0] rd_backlog = 8'h00;
  logic [63:0] qv;
  int errors = 0, total_checks = 0, n;
  // Reset, state_a, config and low-power refresh; decode and map skip the state_a state
  dsac_row_t rows [21] = '{
    '{4'h8, 16'h1014, 32'h0, 1'b0}, '{4'h8, 16'h101C, 32'h0, 1'b0},
    '{4'h8, 16'h1020, 32'h20, 1'b0}, '{4'h8, 16'h1028, 32'h0F0F0F0F, 1'b0},
    '{4'h8, 16'h102C, 32'h08909FBF, 1'b0}, '{4'h8, 16'h1030, 32'hFC8, 1'b0},
    '{4'h8, 16'h1034, 32'h80000, 1'b0}, '{4'h8, 16'h1038, 32'h76543210, 1'b0},
    '{4'h8, 16'h103C, 32'hFEDCBA98, 1'b0}, '{4'h8, 16'h1018, 32'h0, 1'b1},
    '{4'h4, 16'h1014, 32'h0, 1'b0}, '{4'h4, 16'h101C, 32'h0, 1'b0},
    '{4'h4, 16'h1020, 32'hFE, 1'b0}, '{4'h4, 16'h1028, 32'hCF0F0F0F, 1'b0},
    '{4'h4, 16'h102C, 32'hBFBFBFBF, 1'b0}, '{4'h4, 16'h1030, 32'hFFF, 1'b0},
    '{4'h4, 16'h1034, 32'hF0F03, 1'b0}, '{4'h4, 16'h1038, 32'hFFFFFFFF, 1'b0},
    '{4'h4, 16'h103C, 32'hFFFFFFFF, 1'b0}, '{4'h1, 16'h1014, 32'h73, 1'b0},
    '{4'h2, 16'h101C, 32'hFFFF0007, 1'b0}};

  always #12.5 clock = ~clock; // 40 MHz

  dsac_bank dsac_bank_inst (
    .CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PROG_DECODE(prog[0]), .PROG_MAP(prog[1]), .PROG_LOWPWR(prog[2]), .PROG_TURN(prog[3]),
    .PROG_HIT(prog[4]), .PROG_CLASS(prog[5]), .PROG_ESC(prog[6]), .PROG_QV_LO(prog[7]),
    .PROG_QV_HI(prog[8]), .CTRL_STATE(ctrl), .SYS_ADDR(sys_addr), .DEC_ADDR(dec_addr),
    .DEC_PAGE_LSB(dec_page_lsb), .DEC_PATTERN(dec_pattern), .DEC_MODE(dec_mode),
    .REQ_QOS(req_qos), .REQ_CLASS(req_class), .REQ_PRIORITY(req_priority),
    .RANK_IDLE(rank_idle), .REFI_TICK(stb[0]), .MEM_LOW_STATE(mem_low),
    .SREF_REQ(sref_req), .PDOWN_REQ(pdown_req), .MEM_CLK_STOP(clk_stop),
    .WAIT_CLASS(wait_class), .TURN_DONE(stb[3]), .ROW_HIT(stb[1]), .ROW_MISS(stb[2]),
    .RD_BACKLOG(rd_backlog), .TURN_ALLOWED(turn_allowed), .ROW_CAP_HIT(row_cap_hit),
    .ROW_PRECEDENCE(row_precedence), .RD_SUPPRESS(rd_suppress), .ESC_PULSE(esc_pulse));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge clock);
  endtask

  // Strobe held for k edges, so back-to-back ticks never lower and raise at once
  task automatic pulse(int i, int k = 1);
    stb[i] <= 1'b1;
    cyc(k);
    stb[i] <= 1'b0;
  endtask

  // APB transfer; request held until pready is seen high at an edge
  task automatic apb(logic wr, logic [15:0] a, logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    reset_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      ctrl <= rows[i].st;
      cyc(2);
      apb(1'b0, rows[i].a, 32'h0);
      check("prdata", rd, rows[i].d);
      check("pslverr", er, rows[i].e);
    end
    // Writes land nowhere; running state freezes the copies
    ctrl <= 4'h8;
    prog[7] <= 32'h0;
    apb(1'b1, 16'h1038, 32'h0);
    check("wr err", er, 1'b0);
    apb(1'b0, 16'h1038, 32'h0);
    check("after wr", rd, 32'hFFFFFFFF);
    // Functional programming, loaded in the config state
    prog <= '{32'h0, 32'h00FF0005, 32'h3E, 32'h3, 32'h82, 32'hA63, 32'h40200,
              32'h01234567, 32'h89ABCDEF};
    ctrl <= 4'h1;
    cyc(3);
    qv = {32'h89ABCDEF, 32'h01234567};
    for (int q = 0; q < 16; q++) begin
      req_qos <= 4'(q);
      cyc(2);
      check("class", req_class, q >= 10 ? 3 : q >= 6 ? 2 : q >= 3 ? 1 : 0);
      check("prio", req_priority, qv[4*q +: 4]);
    end
    for (int s = 0; s < 8; s++) begin
      prog[0] <= {25'h0, 3'(s), 4'h2};
      cyc(3);
      check("page", dec_page_lsb, s == 0 ? 2'h0 : sys_addr[s+5 +: 2]);
      check("pattern", dec_pattern, 2'h2);
      check("mode", dec_mode, 3'h5);
      check("addr", dec_addr, {sys_addr[43:36], 8'h00, sys_addr[27:0]});
    end
    // Idle rank: three refresh intervals before self-refresh
    rank_idle <= 1'b1;
    mem_low <= 1'b1;
    cyc(1);
    pulse(0, 2);
    cyc(2);
    check("sref early", sref_req, 1'b0);
    pulse(0);
    cyc(2);
    check("sref", sref_req, 1'b1);
    check("pdown", pdown_req, 1'b1);
    check("clkstop", clk_stop, 1'b1);
    rank_idle <= 1'b0;
    prog[2] <= 32'h30;
    cyc(3);
    check("sref busy", sref_req, 1'b0);
    check("clkstop off", clk_stop, 1'b0);
    rank_idle <= 1'b1;
    pulse(0, 4);
    cyc(2);
    check("sref off", sref_req, 1'b0);
    check("pdown off", pdown_req, 1'b0);
    // Row streak cap of two for the lowest class
    pulse(1);
    cyc(2);
    check("cap one", row_cap_hit, 1'b0);
    pulse(1);
    cyc(2);
    check("cap", row_cap_hit, 1'b1);
    check("preced", row_precedence, 1'b1);
    pulse(2);
    cyc(3);
    check("cap miss", row_cap_hit, 1'b0);
    // Turnaround wait of three periods, none for medium
    pulse(3);
    cyc(2);
    check("turn wait", turn_allowed, 1'b0);
    cyc(3);
    check("turn ok", turn_allowed, 1'b1);
    pulse(3);
    wait_class <= 2'h1;
    cyc(2);
    check("turn med", turn_allowed, 1'b1);
    // Backlog threshold: four sixteenths of 32 entries is 8
    rd_backlog <= 8'd7;
    cyc(2);
    check("supp 7", rd_suppress, 1'b0);
    rd_backlog <= 8'd8;
    cyc(2);
    check("supp 8", rd_suppress, 1'b1);
    n = 0;
    repeat (32) begin
      @(posedge clock);
      n += int'(esc_pulse === 1'b1);
    end
    check("esc", n, 16);
    prog[6] <= 32'h0;
    cyc(3);
    n = 0;
    repeat (32) begin
      @(posedge clock);
      n += int'(esc_pulse === 1'b1);
    end
    check("esc off", n, 0);
    // Second reset restores the copies
    ctrl <= 4'h8;
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(2);
    apb(1'b0, 16'h1034, 32'h0);
    check("re-reset", rd, 32'h80000);
    check("mode rst", dec_mode, 3'h0);
    conclude();
  end
endmodule // testbench
`default_nettype wire

//--- hdl/dsac_addr_dec.sv
// Address pre-decode: upper mask and sub-page stripe bits
`timescale 1ns/100ps
`default_nettype none
`include "dsac_cfg.svh"
module dsac_addr_dec
  import dsac_pkg::*;
(
  // Mapping carrier
  dsac_map_if.dec m
);

  // ----------------------------------------------------------------
  // Mask and stripe
  // ----------------------------------------------------------------
  // Instance-select bits lie outside memory, so drop them before decode
  always_comb begin
    m.dec_addr = m.sys_addr;
    m.dec_addr[43:`DSAC_MASK_LSB] = m.sys_addr[43:`DSAC_MASK_LSB] & ~m.addr_mask;
  end

  // Stripe 0 means no striping; otherwise slice [s+6:s+5] stays under bit 14
  always_comb begin
    if (m.stripe == 3'h0) begin
      m.page_lsb = 2'h0;
    end else begin
      m.page_lsb = m.sys_addr[{2'h0, m.stripe} + `DSAC_STRIPE_BASE -: 2];
    end
  end

endmodule // dsac_addr_dec
`default_nettype wire

//--- hdl/dsac_bank.sv
// Active configuration shadow bank with APB access and policy logic
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dsac_cfg.svh"
module dsac_bank
  import dsac_pkg::*;
#(
  parameter int QDEPTH = 32,  // Read queue depth in entries
  parameter int BLW = 8       // Width of the read backlog count
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Programmed values and controller state
  input wire logic [31:0] PROG_DECODE,
  input wire logic [31:0] PROG_MAP,
  input wire logic [31:0] PROG_LOWPWR,
  input wire logic [31:0] PROG_TURN,
  input wire logic [31:0] PROG_HIT,
  input wire logic [31:0] PROG_CLASS,
  input wire logic [31:0] PROG_ESC,
  input wire logic [31:0] PROG_QV_LO,
  input wire logic [31:0] PROG_QV_HI,
  input wire logic [3:0] CTRL_STATE,
  // Address pre-decode
  input wire logic [43:0] SYS_ADDR,
  output logic [43:0] DEC_ADDR,
  output logic [1:0] DEC_PAGE_LSB,
  output logic [1:0] DEC_PATTERN,
  output logic [2:0] DEC_MODE,
  // QoS mapping
  input wire logic [3:0] REQ_QOS,
  output logic [1:0] REQ_CLASS,
  output logic [3:0] REQ_PRIORITY,
  // Low power
  input wire logic RANK_IDLE,
  input wire logic REFI_TICK,
  input wire logic MEM_LOW_STATE,
  output logic SREF_REQ,
  output logic PDOWN_REQ,
  output logic MEM_CLK_STOP,
  // Arbitration
  input wire logic [1:0] WAIT_CLASS,
  input wire logic TURN_DONE,
  input wire logic ROW_HIT,
  input wire logic ROW_MISS,
  input wire logic [BLW-1:0] RD_BACKLOG,
  output logic TURN_ALLOWED,
  output logic ROW_CAP_HIT,
  output logic ROW_PRECEDENCE,
  output logic RD_SUPPRESS,
  output logic ESC_PULSE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Prescaler p gives a tick every 16**p cycles
  function automatic logic presc_tick(input logic [11:0] c, input logic [1:0] p);
    logic t;
    t = 1'b1;
    if (p == 2'h1) begin
      t = &c[3:0];
    end else if (p == 2'h2) begin
      t = &c[7:0];
    end else if (p == 2'h3) begin
      t = &c[11:0];
    end
    return t;
  endfunction

  // Byte-wide lane of a class inside a per-class register
  function automatic logic [7:0] class_lane(input logic [31:0] r, input logic [1:0] cl);
    return r[{cl, 3'h0} +: 8];
  endfunction

  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [31:0] decode_q;  // Decode control shadow
  logic [31:0] map_q;     // Address map shadow
  logic [31:0] lowpwr_q;  // Low-power policy shadow
  logic [31:0] turn_q;    // Turnaround policy shadow
  logic [31:0] hit_q;     // Row-hit limit shadow
  logic [31:0] class_q;   // Class threshold shadow
  logic [31:0] esc_q;     // Escalation shadow
  logic [63:0] qv_q;      // Priority map shadow, both halves
  logic upd_map;          // Address-side refresh window
  logic upd_sched;        // Scheduler-side refresh window

  // Address side refreshes in config or low-power only
  assign upd_map = CTRL_STATE[0] | CTRL_STATE[1];
  // Scheduler side also refreshes while state_a
  assign upd_sched = upd_map | CTRL_STATE[2];

  // Address shadows; reserved bits held at zero
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      decode_q <= `DSAC_RST_DECODE;
      map_q <= `DSAC_RST_MAP;
    end else if (upd_map) begin
      decode_q <= PROG_DECODE & `DSAC_MSK_DECODE;
      map_q <= PROG_MAP & `DSAC_MSK_MAP;
    end
  end

  // Scheduling, low-power and priority shadows
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      lowpwr_q <= `DSAC_RST_LOWPWR;
      turn_q <= `DSAC_RST_TURN;
      hit_q <= `DSAC_RST_HIT;
      class_q <= `DSAC_RST_CLASS;
      esc_q <= `DSAC_RST_ESC;
      qv_q <= {`DSAC_RST_QV_HI, `DSAC_RST_QV_LO};
    end else if (upd_sched) begin
      lowpwr_q <= PROG_LOWPWR & `DSAC_MSK_LOWPWR;
      turn_q <= PROG_TURN & `DSAC_MSK_TURN;
      hit_q <= PROG_HIT & `DSAC_MSK_HIT;
      class_q <= PROG_CLASS & `DSAC_MSK_CLASS;
      esc_q <= PROG_ESC & `DSAC_MSK_ESC;
      qv_q <= {PROG_QV_HI, PROG_QV_LO};
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] rd_d;  // Read data for the addressed word
  logic hit_d;        // Address is mapped

  // Address decode; every word is read-only
  always_comb begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    if (PADDR == `DSAC_OFS_DECODE) begin
      rd_d = decode_q;
    end else if (PADDR == `DSAC_OFS_MAP) begin
      rd_d = map_q;
    end else if (PADDR == `DSAC_OFS_LOWPWR) begin
      rd_d = lowpwr_q;
    end else if (PADDR == `DSAC_OFS_TURN) begin
      rd_d = turn_q;
    end else if (PADDR == `DSAC_OFS_HIT) begin
      rd_d = hit_q;
    end else if (PADDR == `DSAC_OFS_CLASS) begin
      rd_d = class_q;
    end else if (PADDR == `DSAC_OFS_ESC) begin
      rd_d = esc_q;
    end else if (PADDR == `DSAC_OFS_QV_LO) begin
      rd_d = qv_q[31:0];
    end else if (PADDR == `DSAC_OFS_QV_HI) begin
      rd_d = qv_q[63:32];
    end else begin
      hit_d = 1'b0;
    end
  end

  // Answer in the first access cycle; writes to mapped words are dropped
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? 32'h00000000 : rd_d;
      PSLVERR <= !hit_d;
    end else begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mapping helpers
  // ----------------------------------------------------------------
  dsac_map_if mif ();

  assign mif.sys_addr = SYS_ADDR;
  assign mif.addr_mask = map_q[`DSAC_F_ADDR_MASK];
  assign mif.stripe = decode_q[`DSAC_F_STRIPE];
  assign mif.qos = REQ_QOS;
  assign mif.thresholds = class_q[11:0];
  assign mif.qv_map = qv_q;

  dsac_addr_dec u_dec (
    .m(mif.dec)
  );

  dsac_qos_map u_qmap (
    .m(mif.qmap)
  );

  // Register mapping results
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      DEC_ADDR <= 44'h00000000000;
      DEC_PAGE_LSB <= 2'h0;
      DEC_PATTERN <= 2'h0;
      DEC_MODE <= 3'h0;
      REQ_CLASS <= 2'h0;
      REQ_PRIORITY <= 4'h0;
    end else begin
      DEC_ADDR <= mif.dec_addr;
      DEC_PAGE_LSB <= mif.page_lsb;
      DEC_PATTERN <= decode_q[`DSAC_F_PATTERN];
      DEC_MODE <= map_q[`DSAC_F_MAP_MODE];
      REQ_CLASS <= mif.req_class;
      REQ_PRIORITY <= mif.req_prio;
    end
  end

  // ----------------------------------------------------------------
  // Low-power policy
  // ----------------------------------------------------------------
  logic [3:0] idle_cnt_q;  // Refresh intervals spent idle
  logic [3:0] asr_period;  // Programmed idle interval count

  assign asr_period = lowpwr_q[`DSAC_F_ASR_PERIOD];

  // Count intervals while idle; any activity restarts the count
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      idle_cnt_q <= 4'h0;
    end else if (!RANK_IDLE) begin
      idle_cnt_q <= 4'h0;
    end else if (REFI_TICK && idle_cnt_q != 4'hF) begin
      idle_cnt_q <= idle_cnt_q + 4'h1;
    end
  end

  // Period 0 is out of range and treated as never
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      SREF_REQ <= 1'b0;
      PDOWN_REQ <= 1'b0;
      MEM_CLK_STOP <= 1'b0;
    end else begin
      SREF_REQ <= lowpwr_q[`DSAC_B_ASR_EN] && RANK_IDLE && asr_period != 4'h0
                  && idle_cnt_q >= asr_period;
      PDOWN_REQ <= lowpwr_q[`DSAC_B_APD_EN] && RANK_IDLE;
      MEM_CLK_STOP <= lowpwr_q[`DSAC_B_CLK_STOP] && MEM_LOW_STATE;
    end
  end

  // ----------------------------------------------------------------
  // Prescalers
  // ----------------------------------------------------------------
  logic [11:0] presc_q;  // Shared free-running divider
  logic [1:0] tick;      // 0: turnaround, 1: escalation
  logic [1:0] presc_sel [2];

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      presc_q <= 12'h000;
    end else begin
      presc_q <= presc_q + 12'h001;
    end
  end

  assign presc_sel[0] = turn_q[`DSAC_F_TURN_PRESC];
  assign presc_sel[1] = esc_q[`DSAC_F_ESC_PRESC];

  // One enable pulse per prescaler period
  for (genvar g = 0; g < 2; g++) begin : g_tick
    assign tick[g] = presc_tick(presc_q, presc_sel[g]);
  end

  // ----------------------------------------------------------------
  // Turnaround spacing
  // ----------------------------------------------------------------
  logic [3:0] turn_cnt_q;  // Periods since last turnaround
  logic [7:0] turn_limit;  // Lane of the waiting class, limit in [3:0]

  assign turn_limit = class_lane(turn_q, WAIT_CLASS);

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      turn_cnt_q <= 4'h0;
    end else if (TURN_DONE) begin
      turn_cnt_q <= 4'h0;
    end else if (tick[0] && turn_cnt_q != 4'hF) begin
      turn_cnt_q <= turn_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Row-hit streaks
  // ----------------------------------------------------------------
  logic [5:0] streak_q;  // Consecutive row hits
  logic [7:0] hit_lane;  // Cap and precedence of waiting class

  assign hit_lane = class_lane(hit_q, WAIT_CLASS);

  // A miss ends the streak; saturate rather than wrap
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      streak_q <= 6'h00;
    end else if (ROW_MISS) begin
      streak_q <= 6'h00;
    end else if (ROW_HIT && streak_q != 6'h3F) begin
      streak_q <= streak_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Read backlog and escalation
  // ----------------------------------------------------------------
  logic [3:0] esc_cnt_q;    // Periods since last escalation
  logic [3:0] esc_count;    // Programmed escalation spacing
  logic [3:0] rd_frac;      // Backlog threshold in sixteenths
  logic [BLW+4:0] bl_scaled;
  logic [BLW+4:0] bl_limit;

  assign esc_count = esc_q[`DSAC_F_ESC_COUNT];
  assign rd_frac = esc_q[`DSAC_F_RD_SUPPRESS];
  assign bl_scaled = {1'b0, RD_BACKLOG, 4'h0};
  assign bl_limit = (BLW + 5)'(rd_frac * QDEPTH);

  // Count prescaler periods; zero count keeps escalation off
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      esc_cnt_q <= 4'h0;
    end else if (esc_count == 4'h0) begin
      esc_cnt_q <= 4'h0;
    end else if (tick[1]) begin
      esc_cnt_q <= (esc_cnt_q + 4'h1 >= esc_count) ? 4'h0 : esc_cnt_q + 4'h1;
    end
  end

  // Arbitration outputs, all registered
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      TURN_ALLOWED <= 1'b0;
      ROW_CAP_HIT <= 1'b0;
      ROW_PRECEDENCE <= 1'b0;
      RD_SUPPRESS <= 1'b0;
      ESC_PULSE <= 1'b0;
    end else begin
      TURN_ALLOWED <= turn_cnt_q >= turn_limit[3:0];
      ROW_CAP_HIT <= hit_lane[5:0] != 6'h00 && streak_q >= hit_lane[5:0];
      ROW_PRECEDENCE <= hit_lane[7];
      RD_SUPPRESS <= rd_frac != 4'h0 && bl_scaled >= bl_limit;
      ESC_PULSE <= esc_count != 4'h0 && tick[1]
                   && esc_cnt_q + 4'h1 >= esc_count;
    end
  end

endmodule // dsac_bank
`default_nettype wire

//--- hdl/dsac_cfg.svh
// Offsets, field positions, reset values and implemented-bit masks of the active configuration bank
`ifndef DSAC_CFG_SVH
`define DSAC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DSAC_OFS_DECODE 16'h1014
`define DSAC_OFS_MAP 16'h101C
`define DSAC_OFS_LOWPWR 16'h1020
`define DSAC_OFS_TURN 16'h1028
`define DSAC_OFS_HIT 16'h102C
`define DSAC_OFS_CLASS 16'h1030
`define DSAC_OFS_ESC 16'h1034
`define DSAC_OFS_QV_LO 16'h1038
`define DSAC_OFS_QV_HI 16'h103C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSAC_RST_DECODE 32'h00000000
`define DSAC_RST_MAP 32'h00000000
`define DSAC_RST_LOWPWR 32'h00000020
`define DSAC_RST_TURN 32'h0F0F0F0F
`define DSAC_RST_HIT 32'h08909FBF
`define DSAC_RST_CLASS 32'h00000FC8
`define DSAC_RST_ESC 32'h00080000
`define DSAC_RST_QV_LO 32'h76543210
`define DSAC_RST_QV_HI 32'hFEDCBA98

// ----------------------------------------------------------------
// Implemented (non-reserved) bits of each register
// ----------------------------------------------------------------
`define DSAC_MSK_DECODE 32'h00000073
`define DSAC_MSK_MAP 32'hFFFF0007
`define DSAC_MSK_LOWPWR 32'h000000FE
`define DSAC_MSK_TURN 32'hCF0F0F0F
`define DSAC_MSK_HIT 32'hBFBFBFBF
`define DSAC_MSK_CLASS 32'h00000FFF
`define DSAC_MSK_ESC 32'h000F0F03
`define DSAC_MSK_QV 32'hFFFFFFFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSAC_F_STRIPE 6:4
`define DSAC_F_PATTERN 1:0
`define DSAC_F_ADDR_MASK 31:16
`define DSAC_F_MAP_MODE 2:0
`define DSAC_F_ASR_PERIOD 7:4
`define DSAC_B_ASR_EN 3
`define DSAC_B_APD_EN 2
`define DSAC_B_CLK_STOP 1
`define DSAC_F_TURN_PRESC 31:30
`define DSAC_F_MED_START 3:0
`define DSAC_F_HIGH_START 7:4
`define DSAC_F_TOP_START 11:8
`define DSAC_F_RD_SUPPRESS 19:16
`define DSAC_F_ESC_COUNT 11:8
`define DSAC_F_ESC_PRESC 1:0
`define DSAC_MASK_LSB 28
`define DSAC_STRIPE_BASE 6

`endif

//--- hdl/dsac_map_if.sv
// Carrier between the bank and its address and QoS mapping helpers
`timescale 1ns/100ps
`default_nettype none
interface dsac_map_if;
  import dsac_pkg::*;
  logic [43:0] sys_addr;   // Raw system address
  logic [15:0] addr_mask;  // Upper address mask
  logic [2:0] stripe;      // Stripe boundary select
  logic [43:0] dec_addr;   // Address with upper bits dropped
  logic [1:0] page_lsb;    // Derived page low bits
  logic [3:0] qos;         // Incoming QoS value
  logic [11:0] thresholds; // Class start values
  logic [63:0] qv_map;     // Priority nibble per QoS value
  dsac_class_t req_class;  // Resulting class
  logic [3:0] req_prio;    // Resulting priority

  modport bank (output sys_addr, addr_mask, stripe, qos, thresholds, qv_map,
                input dec_addr, page_lsb, req_class, req_prio);
  modport dec (input sys_addr, addr_mask, stripe, output dec_addr, page_lsb);
  modport qmap (input qos, thresholds, qv_map, output req_class, req_prio);
endinterface
`default_nettype wire

//--- hdl/dsac_pkg.sv
// Types shared by the active configuration bank
package dsac_pkg;

  // Controller operating state, one-hot
  typedef enum logic [3:0] {
    DSAC_ST_CONFIG = 4'h1,
    DSAC_ST_LOWPWR = 4'h2,
    DSAC_ST_STATE_A = 4'h4,
    DSAC_ST_RUN = 4'h8
  } dsac_ctrl_t;

  // Arbitration class, lowest to highest
  typedef enum logic [1:0] {
    DSAC_CL_LOW = 2'h0,
    DSAC_CL_MED = 2'h1,
    DSAC_CL_HIGH = 2'h2,
    DSAC_CL_TOP = 2'h3
  } dsac_class_t;

endpackage

//--- hdl/dsac_qos_map.sv
// QoS value to class and queueing priority
`timescale 1ns/100ps
`default_nettype none
`include "dsac_cfg.svh"
module dsac_qos_map
  import dsac_pkg::*;
(
  // Mapping carrier
  dsac_map_if.qmap m
);

  // ----------------------------------------------------------------
  // Class by threshold, highest match wins
  // ----------------------------------------------------------------
  always_comb begin
    if (m.qos >= m.thresholds[`DSAC_F_TOP_START]) begin
      m.req_class = DSAC_CL_TOP;
    end else if (m.qos >= m.thresholds[`DSAC_F_HIGH_START]) begin
      m.req_class = DSAC_CL_HIGH;
    end else if (m.qos >= m.thresholds[`DSAC_F_MED_START]) begin
      m.req_class = DSAC_CL_MED;
    end else begin
      m.req_class = DSAC_CL_LOW;
    end
  end

  // One nibble per value, higher values in higher nibbles
  assign m.req_prio = m.qv_map[{m.qos, 2'h0} +: 4];

endmodule // dsac_qos_map
`default_nettype wire
